// >>> logic/tlp_prioritizer.sv
// Three level interrupt prioritizer with APB register slave
module tlp_prioritizer (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Request lines, in polling order
  input wire logic [11:0] src_req_i,
  // Core handshake
  input wire logic int_ack_i,
  input wire logic reti_i,
  output tlp_pkg::tlp_vec_s core_vec_o,
  output logic [2:0] in_service_o,
  // Power management
  output logic core_off_o,
  output logic wake_o,
  // Event interrupt
  output logic irq_o
);

  // Registers
  logic [7:0] enable_ff;
  logic [7:0] source_priority_select_ff;
  logic [7:0] secondary_enable_priority_ff;
  logic [2:0] pwr_ff;
  logic [11:0] wake_mask_ff;
  logic [2:0] ev_en_ff;
  logic [2:0] ev_stat;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  tlp_pkg::tlp_vec_s vec_ff;
  tlp_pkg::tlp_vec_s nxt_vec;
  logic [2:0] in_service_ff;
  logic [2:0] nxt_in_service;
  logic wake_ff;
  logic irq_ff;

  // Derived signals
  logic bus_done;
  logic bus_wr;
  logic [11:0] src_en;
  logic [11:0] src_hi;
  logic [11:0] pending;
  logic [11:0] lvl_req [3];
  logic [2:0] lvl_any;
  logic [3:0] lvl_idx [3];
  logic [2:0] ack_mask;
  logic [2:0] ret_mask;
  logic ack_take;
  logic wake_hit;

  // Address decode shared by read and write paths
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == tlp_pkg::ADDR_ENABLE) || (a == tlp_pkg::ADDR_SEC) ||
      (a == tlp_pkg::ADDR_PRIO) || (a == tlp_pkg::ADDR_EV_STAT) ||
      (a == tlp_pkg::ADDR_EV_CLR) || (a == tlp_pkg::ADDR_EV_EN) ||
      (a == tlp_pkg::ADDR_PWR) || (a == tlp_pkg::ADDR_WAKE_MASK) ||
      (a == tlp_pkg::ADDR_SVC_STAT);
  endfunction

  // Highest set in-service flag, used to pick which one a return ends
  function automatic logic [2:0] top_flag(input logic [2:0] f);
    if (f[tlp_pkg::LVL_TOP])
      top_flag = 3'h4;
    else if (f[tlp_pkg::LVL_HIGH])
      top_flag = 3'h2;
    else
      top_flag = {2'h0, f[tlp_pkg::LVL_LOW]};
  endfunction

  // APB transfer completes on the edge that sees pready high
  assign bus_done = psel_i & penable_i & pready_ff;
  assign bus_wr = bus_done & pwrite_i & addr_mapped(paddr_i);

  // One wait state: pready high in the second access cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pready_ff <= 1'b0;
    else
      pready_ff <= psel_i & penable_i & ~pready_ff;
  end

  // Error flag for unmapped addresses, timed with pready
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pslverr_ff <= 1'b0;
    else
      pslverr_ff <= psel_i & penable_i & ~pready_ff & ~addr_mapped(paddr_i);
  end

  // Read data captured with pready; unmapped and write-only read zero
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      prdata_ff <= 32'h0000_0000;
    else if (psel_i & penable_i & ~pready_ff & ~pwrite_i)
    begin
      unique case (paddr_i)
        tlp_pkg::ADDR_ENABLE: prdata_ff <= {24'h0, enable_ff};
        tlp_pkg::ADDR_SEC: prdata_ff <= {24'h0, secondary_enable_priority_ff};
        tlp_pkg::ADDR_PRIO: prdata_ff <= {24'h0, source_priority_select_ff};
        tlp_pkg::ADDR_EV_STAT: prdata_ff <= {29'h0, ev_stat};
        tlp_pkg::ADDR_EV_EN: prdata_ff <= {29'h0, ev_en_ff};
        tlp_pkg::ADDR_PWR: prdata_ff <= {29'h0, pwr_ff};
        tlp_pkg::ADDR_WAKE_MASK: prdata_ff <= {20'h0, wake_mask_ff};
        tlp_pkg::ADDR_SVC_STAT: prdata_ff <= {22'h0, vec_ff, in_service_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Enable register, bit 7 is the global gate
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      enable_ff <= tlp_pkg::ENABLE_RST;
    else if (bus_wr && paddr_i == tlp_pkg::ADDR_ENABLE)
      enable_ff <= pwdata_i[7:0];
  end

  // Priority select register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      source_priority_select_ff <= tlp_pkg::PRIO_RST;
    else if (bus_wr && paddr_i == tlp_pkg::ADDR_PRIO)
      source_priority_select_ff <= pwdata_i[7:0];
  end

  // Secondary enable and priority; reserved bits keep their reset value
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      secondary_enable_priority_ff <= tlp_pkg::SEC_RST;
    else if (bus_wr && paddr_i == tlp_pkg::ADDR_SEC)
      secondary_enable_priority_ff <=
        (pwdata_i[7:0] & ~tlp_pkg::SEC_RSVD_MASK) | tlp_pkg::SEC_RSVD_MASK;
  end

  // Wake-up source mask
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      wake_mask_ff <= tlp_pkg::WAKE_MASK_RST;
    else if (bus_wr && paddr_i == tlp_pkg::ADDR_WAKE_MASK)
      wake_mask_ff <= pwdata_i[11:0];
  end

  // Event interrupt enable
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ev_en_ff <= 3'h0;
    else if (bus_wr && paddr_i == tlp_pkg::ADDR_EV_EN)
      ev_en_ff <= pwdata_i[2:0];
  end

  // Wake hit only counts while the core is off
  assign wake_hit = pwr_ff[tlp_pkg::PWR_CORE_OFF] &
    (|(src_req_i & wake_mask_ff));

  // Power control; a wake-up clears core off ahead of any write
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pwr_ff <= tlp_pkg::PWR_RST;
    else
    begin
      if (bus_wr && paddr_i == tlp_pkg::ADDR_PWR)
        pwr_ff <= pwdata_i[2:0];
      if (wake_hit)
        pwr_ff[tlp_pkg::PWR_CORE_OFF] <= 1'b0;
    end
  end

  // Wake pulse to the core clock controller
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      wake_ff <= 1'b0;
    else
      wake_ff <= wake_hit;
  end

  // Per-source enables gathered into polling order
  assign src_en[tlp_pkg::SRC_SUPPLY] =
    secondary_enable_priority_ff[tlp_pkg::SEC_EN_SUPPLY];
  assign src_en[tlp_pkg::SRC_RTC] =
    secondary_enable_priority_ff[tlp_pkg::SEC_EN_RTC];
  assign src_en[tlp_pkg::SRC_ENERGY] =
    secondary_enable_priority_ff[tlp_pkg::SEC_EN_ENERGY];
  assign src_en[tlp_pkg::SRC_WDT] = pwr_ff[tlp_pkg::PWR_WDT_EN];
  assign src_en[tlp_pkg::SRC_TEMP] = enable_ff[tlp_pkg::EN_TEMP];
  assign src_en[tlp_pkg::SRC_EXT0] = enable_ff[tlp_pkg::EN_EXT0];
  assign src_en[tlp_pkg::SRC_TMR0] = enable_ff[tlp_pkg::EN_TMR0];
  assign src_en[tlp_pkg::SRC_EXT1] = enable_ff[tlp_pkg::EN_EXT1];
  assign src_en[tlp_pkg::SRC_TMR1] = enable_ff[tlp_pkg::EN_TMR1];
  assign src_en[tlp_pkg::SRC_SPI] =
    secondary_enable_priority_ff[tlp_pkg::SEC_EN_SPI];
  assign src_en[tlp_pkg::SRC_UART] = enable_ff[tlp_pkg::EN_UART];
  assign src_en[tlp_pkg::SRC_TMR2] = enable_ff[tlp_pkg::EN_TMR2];

  // Priority bits gathered into polling order; supply has its own level
  assign src_hi[tlp_pkg::SRC_SUPPLY] = 1'b0;
  assign src_hi[tlp_pkg::SRC_RTC] =
    secondary_enable_priority_ff[tlp_pkg::SEC_PR_RTC];
  assign src_hi[tlp_pkg::SRC_ENERGY] =
    source_priority_select_ff[tlp_pkg::PR_ENERGY];
  assign src_hi[tlp_pkg::SRC_WDT] = pwr_ff[tlp_pkg::PWR_WDT_PRI];
  assign src_hi[tlp_pkg::SRC_TEMP] =
    source_priority_select_ff[tlp_pkg::PR_TEMP];
  assign src_hi[tlp_pkg::SRC_EXT0] =
    source_priority_select_ff[tlp_pkg::PR_EXT0];
  assign src_hi[tlp_pkg::SRC_TMR0] =
    source_priority_select_ff[tlp_pkg::PR_TMR0];
  assign src_hi[tlp_pkg::SRC_EXT1] =
    source_priority_select_ff[tlp_pkg::PR_EXT1];
  assign src_hi[tlp_pkg::SRC_TMR1] =
    source_priority_select_ff[tlp_pkg::PR_TMR1];
  assign src_hi[tlp_pkg::SRC_SPI] =
    secondary_enable_priority_ff[tlp_pkg::SEC_PR_SPI];
  assign src_hi[tlp_pkg::SRC_UART] =
    source_priority_select_ff[tlp_pkg::PR_UART];
  assign src_hi[tlp_pkg::SRC_TMR2] =
    source_priority_select_ff[tlp_pkg::PR_TMR2];

  // Gate, enables and core state qualify the twelve requests
  assign pending = src_req_i & src_en &
    {12{enable_ff[tlp_pkg::EN_GATE]}} &
    {12{~pwr_ff[tlp_pkg::PWR_CORE_OFF]}};

  // Split into the three levels
  assign lvl_req[tlp_pkg::LVL_TOP] = pending & tlp_pkg::SUPPLY_MASK;
  assign lvl_req[tlp_pkg::LVL_HIGH] =
    pending & src_hi & ~tlp_pkg::SUPPLY_MASK;
  assign lvl_req[tlp_pkg::LVL_LOW] =
    pending & ~src_hi & ~tlp_pkg::SUPPLY_MASK;

  // One fixed order picker per level
  for (genvar l = 0; l < tlp_pkg::NUM_LVL; l++)
  begin : g_pick
    tlp_pick u_pick (
      .req_i(lvl_req[l]),
      .any_o(lvl_any[l]),
      .idx_o(lvl_idx[l])
    );
  end

  // Highest level wins, and only if nothing of that level or above runs
  always_comb
  begin
    nxt_vec = '0;
    if (lvl_any[tlp_pkg::LVL_TOP] && !in_service_ff[tlp_pkg::LVL_TOP])
    begin
      nxt_vec.req = 1'b1;
      nxt_vec.lvl = tlp_pkg::LVL_TOP;
      nxt_vec.vec = lvl_idx[tlp_pkg::LVL_TOP];
    end
    else if (lvl_any[tlp_pkg::LVL_HIGH] &&
      !in_service_ff[tlp_pkg::LVL_TOP] && !in_service_ff[tlp_pkg::LVL_HIGH])
    begin
      nxt_vec.req = 1'b1;
      nxt_vec.lvl = tlp_pkg::LVL_HIGH;
      nxt_vec.vec = lvl_idx[tlp_pkg::LVL_HIGH];
    end
    else if (lvl_any[tlp_pkg::LVL_LOW] && in_service_ff == 3'h0)
    begin
      nxt_vec.req = 1'b1;
      nxt_vec.lvl = tlp_pkg::LVL_LOW;
      nxt_vec.vec = lvl_idx[tlp_pkg::LVL_LOW];
    end
  end

  // Core takes the standing request with int_ack_i
  assign ack_take = int_ack_i & vec_ff.req;

  // Vector request; dropped for one cycle after an acknowledge
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      vec_ff <= '0;
    else if (ack_take)
      vec_ff <= '0;
    else
      vec_ff <= nxt_vec;
  end

  // In-service flags: return ends the top one, acknowledge sets its level
  assign ret_mask = reti_i ? top_flag(in_service_ff) : 3'h0;
  assign ack_mask = ack_take ? (3'h1 << vec_ff.lvl) : 3'h0;
  assign nxt_in_service = (in_service_ff & ~ret_mask) | ack_mask;

  // In-service register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      in_service_ff <= 3'h0;
    else
      in_service_ff <= nxt_in_service;
  end

  // Events: vector taken, preemption, wake-up
  assign ev_set[tlp_pkg::EV_VECTOR] = ack_take;
  assign ev_set[tlp_pkg::EV_PREEMPT] = ack_take & (|in_service_ff);
  assign ev_set[tlp_pkg::EV_WAKE] = wake_hit;
  assign ev_clr = (bus_wr && paddr_i == tlp_pkg::ADDR_EV_CLR) ?
    pwdata_i[2:0] : 3'h0;

  // Sticky event status
  tlp_sticky u_sticky (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .flags_o(ev_stat)
  );

  // Level interrupt while an enabled event bit is set
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(ev_stat & ev_en_ff);
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign core_vec_o = vec_ff;
  assign in_service_o = in_service_ff;
  assign core_off_o = pwr_ff[tlp_pkg::PWR_CORE_OFF];
  assign wake_o = wake_ff;
  assign irq_o = irq_ff;

endmodule

// >>> logic/tlp_pkg.sv
// Constants, register map and carrier types of the interrupt prioritizer
// Summary of operation
// - Twelve request sources are arbitrated over exactly three levels.
// - Only the supply manager request sits on the top level.
// - Each other source goes to the high or low level by its priority bit.
// - A high level request preempts a running low level routine.
// - Requests of different levels arriving together go higher level first.
// - A request never preempts a routine running on its own level.
// - Several pending requests of one level are chosen by a fixed order.
// - The supply manager request can preempt any running high or low level routine.
// - In core off mode enabled wake-up events restart the core.
// - Interrupts are vectored only while the core is active.
// - The polling order runs from supply monitor (0) to timer 2 (11).
// - The global gate, bit 7 of the enable register, gates every source.
package tlp_pkg;

  // Sizes
  localparam int NUM_SRC = 12;
  localparam int NUM_LVL = 3;
  localparam int ADDR_W = 12;
  localparam int VEC_W = 4;
  localparam int LVL_W = 2;
  localparam int EV_W = 3;

  // Polling order, index 0 polled first
  localparam int SRC_SUPPLY = 0;
  localparam int SRC_RTC = 1;
  localparam int SRC_ENERGY = 2;
  localparam int SRC_WDT = 3;
  localparam int SRC_TEMP = 4;
  localparam int SRC_EXT0 = 5;
  localparam int SRC_TMR0 = 6;
  localparam int SRC_EXT1 = 7;
  localparam int SRC_TMR1 = 8;
  localparam int SRC_SPI = 9;
  localparam int SRC_UART = 10;
  localparam int SRC_TMR2 = 11;
  localparam logic [11:0] SUPPLY_MASK = 12'h001;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_SEC = 8'hA9;
  localparam logic [7:0] IDX_PRIO = 8'hB8;
  localparam logic [7:0] IDX_EV_STAT = 8'hF0;
  localparam logic [7:0] IDX_EV_CLR = 8'hF1;
  localparam logic [7:0] IDX_EV_EN = 8'hF2;
  localparam logic [7:0] IDX_PWR = 8'hF3;
  localparam logic [7:0] IDX_WAKE_MASK = 8'hF4;
  localparam logic [7:0] IDX_SVC_STAT = 8'hF5;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SEC = {2'h0, IDX_SEC, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRIO = {2'h0, IDX_PRIO, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EV_STAT = {2'h0, IDX_EV_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EV_CLR = {2'h0, IDX_EV_CLR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EV_EN = {2'h0, IDX_EV_EN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PWR = {2'h0, IDX_PWR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_WAKE_MASK = {2'h0, IDX_WAKE_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SVC_STAT = {2'h0, IDX_SVC_STAT, 2'h0};

  // Reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] SEC_RST = 8'hA0;
  localparam logic [7:0] SEC_RSVD_MASK = 8'hA0;
  localparam logic [2:0] PWR_RST = 3'h0;
  localparam logic [11:0] WAKE_MASK_RST = 12'h000;

  // Enable register fields
  localparam int EN_EXT0 = 0;
  localparam int EN_TMR0 = 1;
  localparam int EN_EXT1 = 2;
  localparam int EN_TMR1 = 3;
  localparam int EN_UART = 4;
  localparam int EN_TMR2 = 5;
  localparam int EN_TEMP = 6;
  localparam int EN_GATE = 7;

  // Priority register fields (1 = high level)
  localparam int PR_EXT0 = 0;
  localparam int PR_TMR0 = 1;
  localparam int PR_EXT1 = 2;
  localparam int PR_TMR1 = 3;
  localparam int PR_UART = 4;
  localparam int PR_TMR2 = 5;
  localparam int PR_TEMP = 6;
  localparam int PR_ENERGY = 7;

  // Secondary enable and priority fields
  localparam int SEC_EN_SPI = 0;
  localparam int SEC_EN_SUPPLY = 1;
  localparam int SEC_EN_RTC = 2;
  localparam int SEC_EN_ENERGY = 3;
  localparam int SEC_PR_SPI = 4;
  localparam int SEC_PR_RTC = 6;

  // Power control fields
  localparam int PWR_CORE_OFF = 0;
  localparam int PWR_WDT_EN = 1;
  localparam int PWR_WDT_PRI = 2;

  // Sticky event bits
  localparam int EV_VECTOR = 0;
  localparam int EV_PREEMPT = 1;
  localparam int EV_WAKE = 2;

  // Levels
  localparam logic [LVL_W-1:0] LVL_LOW = 2'h0;
  localparam logic [LVL_W-1:0] LVL_HIGH = 2'h1;
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h2;

  // Vector request towards the core
  typedef struct packed {
    logic req;
    logic [LVL_W-1:0] lvl;
    logic [VEC_W-1:0] vec;
  } tlp_vec_s;

endpackage

// >>> logic/tlp_pick.sv
// Fixed order picker: lowest set index wins
module tlp_pick (
  // Requests, index 0 first in order
  input wire logic [11:0] req_i,
  // Result
  output logic any_o,
  output logic [3:0] idx_o
);

  // Scan from the last index down so the lowest set one stays
  always_comb
  begin
    any_o = |req_i;
    idx_o = 4'h0;
    for (int i = tlp_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        idx_o = 4'(i);
      end
    end
  end

endmodule

// >>> logic/tlp_sticky.sv
// Sticky event flags, set wins over clear
module tlp_sticky (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Events and software clear
  input wire logic [2:0] set_i,
  input wire logic [2:0] clr_i,
  // Flags
  output logic [2:0] flags_o
);

  logic [2:0] flags_ff;

  // Hold until cleared; a same-cycle event survives the clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      flags_ff <= 3'h0;
    else
      flags_ff <= (flags_ff & ~clr_i) | set_i;
  end

  assign flags_o = flags_ff;

endmodule

// >>> tb/tlp_core_model.sv
// Core model: takes offered vectors and returns from service
module tlp_core_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Offer and bench controls
  input wire tlp_pkg::tlp_vec_s vec_i,
  input wire logic [1:0] wait_i,
  input wire logic ret_i,
  input wire logic auto_ret_i,
  // Handshake towards the block
  output logic int_ack_o,
  output logic reti_o
);
  logic [1:0] cnt_ff;
  logic [2:0] run_ff;

  // Acknowledge once the offer has stood wait_i cycles
  always_ff @(posedge clk_sys_i)
  begin
    cnt_ff <= (!rst_n_i || !vec_i.req || int_ack_o) ? 2'h0 : cnt_ff + 2'h1;
    int_ack_o <= rst_n_i && vec_i.req && !int_ack_o && cnt_ff >= wait_i;
  end

  // Return a few cycles after a taken vector, or on bench request
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      run_ff <= 3'h0;
    else if (int_ack_o && vec_i.req && auto_ret_i)
      run_ff <= 3'h1;
    else if (run_ff != 3'h0)
      run_ff <= run_ff + 3'h1;
    reti_o <= rst_n_i && (ret_i || run_ff == 3'h5);
  end
endmodule

// >>> tb/tlp_prioritizer_asserts.sv
// Port assertions of the interrupt prioritizer
module tlp_prioritizer_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Observed ports
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic [11:0] src_req_i,
  input wire logic int_ack_i,
  input wire logic reti_i,
  input wire tlp_pkg::tlp_vec_s core_vec_o,
  input wire logic [2:0] in_service_o,
  input wire logic core_off_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic take;
  logic take_hi;

  // Vector taken by the core
  assign take = int_ack_i && core_vec_o.req;
  assign take_hi = take && core_vec_o.lvl == 2'h1;

  property p_apb_wait;
    psel_i && !penable_i |=> !pready_o ##1 pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("register answer not in second access cycle");
  property p_ack_drop;
    take |=> !core_vec_o.req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("offer stands after acknowledge");
  property p_top_set;
    take && core_vec_o.lvl == 2'h2 |=> in_service_o[2];
  endproperty
  a_top_set: assert property (p_top_set)
    else $error("top level not in service after acknowledge");
  property p_low_block;
    core_vec_o.req && core_vec_o.lvl == 2'h0 |-> in_service_o == 3'h0;
  endproperty
  a_low_block: assert property (p_low_block)
    else $error("low offer while a routine runs");
  property p_same_block;
    core_vec_o.req && core_vec_o.lvl == 2'h1 |-> in_service_o[2:1] == 2'h0;
  endproperty
  a_same_block: assert property (p_same_block)
    else $error("high offer while high or top runs");
  property p_top_only;
    core_vec_o.req |-> (core_vec_o.lvl == 2'h2) == (core_vec_o.vec == 4'h0);
  endproperty
  a_top_only: assert property (p_top_only)
    else $error("top level not tied to supply source");
  property p_cause;
    core_vec_o.req |-> (($past(src_req_i) >> core_vec_o.vec) & 12'h001) != 0;
  endproperty
  a_cause: assert property (p_cause)
    else $error("offer without a request");
  property p_off_quiet;
    core_off_o && $past(core_off_o) |-> !core_vec_o.req;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("offer while core off");
  property p_wake;
    wake_o |-> !core_off_o && $past(core_off_o) ##1 !wake_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse not from core off");
  property p_reti_top;
    reti_i && !int_ack_i && in_service_o[2] |=> !in_service_o[2];
  endproperty
  a_reti_top: assert property (p_reti_top)
    else $error("return left top level in service");
  property p_hi_cause;
    $rose(in_service_o[1]) |-> $past(take_hi);
  endproperty
  a_hi_cause: assert property (p_hi_cause)
    else $error("high in service without acknowledge");
endmodule

bind tlp_prioritizer tlp_prioritizer_asserts u_asserts (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .src_req_i(src_req_i),
  .int_ack_i(int_ack_i), .reti_i(reti_i), .core_vec_o(core_vec_o),
  .in_service_o(in_service_o), .core_off_o(core_off_o), .wake_o(wake_o)
);

// >>> tb/tlp_prioritizer_bench.sv
// Self-checking bench of the three level interrupt prioritizer
module tlp_prioritizer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, src_req, m, a_r;
  logic [31:0] pwdata, prdata;
  logic int_ack, reti, ret, auto_ret, core_off, wake, irq, err, wr_r;
  logic [1:0] wait_sel;
  logic [2:0] in_svc, w;
  logic [7:0] p, s;
  tlp_pkg::tlp_vec_s vec;
  logic [5:0] vq[$];
  logic [32:0] rq[$];
  int mismatches, num_checks, seed, wakes;

  // 200 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  tlp_prioritizer dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .src_req_i(src_req), .int_ack_i(int_ack),
    .reti_i(reti), .core_vec_o(vec), .in_service_o(in_svc),
    .core_off_o(core_off), .wake_o(wake), .irq_o(irq)
  );

  tlp_core_model core (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .vec_i(vec),
    .wait_i(wait_sel), .ret_i(ret), .auto_ret_i(auto_ret),
    .int_ack_o(int_ack), .reti_o(reti)
  );

  task automatic check(input string what, input logic [32:0] got,
    input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer, waiting on pready with a bound
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (!pready && n < 50);
    if (!pready)
    begin
      mismatches++;
      finish_test();
    end
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Wait until every noted vector was taken
  task automatic drain();
    int n;
    n = 0;
    while (vq.size() != 0 && n < 300)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    if (vq.size() != 0)
    begin
      mismatches++;
      finish_test();
    end
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic ret_pulse();
    ret <= 1'b1;
    @(posedge clk_sys_i);
    ret <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // Level of each source under the current p, s, w settings
  function automatic logic [1:0] lvl_of(input int i);
    case (i)
      0: return 2'h2;
      1: return {1'b0, s[6]};
      2: return {1'b0, p[7]};
      3: return {1'b0, w[2]};
      4: return {1'b0, p[6]};
      9: return {1'b0, s[4]};
      10: return {1'b0, p[4]};
      11: return {1'b0, p[5]};
      default: return {1'b0, p[i-5]};
    endcase
  endfunction

  // Monitor: taken vectors, read answers, wake pulses; source drops
  always @(posedge clk_sys_i)
  begin
    if (int_ack && vec.req)
    begin
      src_req[vec.vec] <= 1'b0;
      check("vector", {27'h0, vec.lvl, vec.vec},
        vq.size() ? {27'h0, vq.pop_front()} : 33'h3F);
    end
    if (psel && penable && pready && !pwrite)
      check("read", {pslverr, prdata},
        rq.size() ? rq.pop_front() : 33'h1FFFFFFFF);
    if (wake)
      wakes++;
  end

  // Main sequence
  initial
  begin
    seed = 78;
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_req = 12'h000;
    ret = 1'b0;
    auto_ret = 1'b1;
    wait_sel = 2'h0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(tlp_pkg::ADDR_ENABLE, 33'h0);
    rd(tlp_pkg::ADDR_SEC, 33'hA0);
    rd(tlp_pkg::ADDR_PRIO, 33'h0);
    rd(12'h004, 33'h100000000);
    apb(1'b1, tlp_pkg::ADDR_SEC, 32'h0F);
    rd(tlp_pkg::ADDR_SEC, 33'hAF);
    apb(1'b1, tlp_pkg::ADDR_ENABLE, 32'hFF);
    // Random levels, simultaneous requests, order checked by monitor
    for (int r = 0; r < 8; r++)
    begin
      p = 8'($random(seed));
      s = 8'($random(seed)) & 8'h50 | 8'h0F;
      w = {1'($random(seed)), 2'h2};
      m = 12'($random(seed));
      wait_sel <= 2'($random(seed));
      apb(1'b1, tlp_pkg::ADDR_PRIO, {24'h0, p});
      apb(1'b1, tlp_pkg::ADDR_SEC, {24'h0, s});
      apb(1'b1, tlp_pkg::ADDR_PWR, {29'h0, w});
      for (int l = 2; l >= 0; l--)
        for (int i = 0; i < 12; i++)
          if (m[i] && lvl_of(i) == 2'(l))
            vq.push_back({2'(l), 4'(i)});
      src_req <= m;
      drain();
      // Random unmapped access in either direction must answer an error
      wr_r = 1'($random(seed));
      a_r = {2'h0, 8'($random(seed)) & 8'h7F, 2'h0};
      if (!wr_r)
        rq.push_back(33'h100000000);
      apb(wr_r, a_r, 32'($random(seed)));
      check("slverr", 33'(err), 33'h1);
    end
    // Nested service across the three levels
    auto_ret <= 1'b0;
    apb(1'b1, tlp_pkg::ADDR_PRIO, 32'h01);
    vq.push_back(6'h06);
    src_req[6] <= 1'b1;
    drain();
    check("in_service", in_svc, 3'h1);
    src_req[8] <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    check("offer", vec.req, 1'b0);
    vq.push_back(6'h15);
    src_req[5] <= 1'b1;
    drain();
    check("in_service", in_svc, 3'h3);
    vq.push_back(6'h20);
    src_req[0] <= 1'b1;
    drain();
    check("in_service", in_svc, 3'h7);
    ret_pulse();
    check("in_service", in_svc, 3'h3);
    ret_pulse();
    check("in_service", in_svc, 3'h1);
    vq.push_back(6'h08);
    ret_pulse();
    drain();
    ret_pulse();
    auto_ret <= 1'b1;
    // Global gate holds every source back, supply included
    apb(1'b1, tlp_pkg::ADDR_ENABLE, 32'h7F);
    src_req <= 12'h041;
    repeat (12) @(posedge clk_sys_i);
    check("offer", vec.req, 1'b0);
    vq.push_back(6'h20);
    vq.push_back(6'h06);
    apb(1'b1, tlp_pkg::ADDR_ENABLE, 32'hFF);
    drain();
    // Core off: no vectoring, wake-up by mask, event flag and interrupt
    apb(1'b1, tlp_pkg::ADDR_EV_CLR, 32'h7);
    apb(1'b1, tlp_pkg::ADDR_EV_EN, 32'h4);
    apb(1'b1, tlp_pkg::ADDR_ENABLE, 32'h84);
    apb(1'b1, tlp_pkg::ADDR_WAKE_MASK, 32'h020);
    apb(1'b1, tlp_pkg::ADDR_PWR, 32'h3);
    src_req[7] <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    check("offer", vec.req, 1'b0);
    check("core_off", core_off, 1'b1);
    vq.push_back(6'h07);
    src_req[5] <= 1'b1;
    drain();
    src_req[5] <= 1'b0;
    check("wakes", 33'(wakes), 33'h1);
    check("core_off", core_off, 1'b0);
    check("irq", irq, 1'b1);
    rd(tlp_pkg::ADDR_EV_STAT, 33'h5);
    apb(1'b1, tlp_pkg::ADDR_EV_EN, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    check("irq", irq, 1'b0);
    apb(1'b1, tlp_pkg::ADDR_EV_EN, 32'h4);
    apb(1'b1, tlp_pkg::ADDR_EV_CLR, 32'h4);
    repeat (2) @(posedge clk_sys_i);
    check("irq", irq, 1'b0);
    rd(tlp_pkg::ADDR_EV_STAT, 33'h1);
    finish_test();
  end
endmodule
